// ### verilog/tpc_pin_ctrl.sv
// Purpose: Pin control for two timers, registers on a Wishbone classic slave
// Assumes: Timer cores sit outside and exchange timer_out and timer_in levels
// Notes:   Ack one cycle after a request, err on unmapped addresses
`timescale 1ns/100ps
module tpc_pin_ctrl
  import tpc_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // Register bus
  input  wire tpc_pkg::tpc_wb_req_s     wb_req,
  output tpc_pkg::tpc_wb_rsp_s          wb_rsp,
  // Timer core side
  input  wire logic [1:0]               timer_out,
  output logic [1:0]                    timer_in,
  output tpc_pkg::tpc_mode_e [1:0]      timer_mode,
  // Pins, timer0_pin and timer1_pin
  input  wire logic [1:0]               timer_pin_i,
  output logic [1:0]                    timer_pin_o,
  output logic [1:0]                    timer_pin_oe
);

  typedef struct packed {
    tpc_csr_s    timer0_ctrl_status_reg;
    tpc_csr_s    timer1_ctrl_status_reg;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } tpc_state_s;

  tpc_state_s              state_reg;
  tpc_state_s              state_next;
  tpc_csr_s [1:0]          csr;
  tpc_pin_out_s [1:0]      pin;
  logic [1:0]              level;
  logic                    req;
  logic                    hit0;
  logic                    hit1;
  logic                    hitl;

  assign csr = {state_reg.timer1_ctrl_status_reg, state_reg.timer0_ctrl_status_reg};

  generate
    for (genvar i = 0; i < NUM_TIMERS; i++)
    begin : g_pin
      tpc_pin_cell u_cell (
        .core_clk  (core_clk),
        .rst       (rst),
        .csr       (csr[i]),
        .timer_out (timer_out[i]),
        .pin_i     (timer_pin_i[i]),
        .pin       (pin[i]),
        .level     (level[i]),
        .timer_in  (timer_in[i])
      );
      assign timer_pin_o[i]  = pin[i].o;
      assign timer_pin_oe[i] = pin[i].oe;
      assign timer_mode[i]   = csr[i].mode;
    end
  endgenerate

  function automatic tpc_csr_s csr_write(tpc_csr_s old, logic [3:0] sel, logic [31:0] d);
    tpc_csr_s n;
    n = old;
    if (sel[0])
    begin
      if (d[PINSEL_LSB +: 2] <= 2'h2)
      begin
        n.pinsel = tpc_pinsel_e'(d[PINSEL_LSB +: 2]);
      end
      if (d[MODE_LSB +: 3] <= 3'h4)
      begin
        n.mode = tpc_mode_e'(d[MODE_LSB +: 3]);
      end
    end
    if (sel[1])
    begin
      n.gpo_level = d[GPO_BIT];
    end
    return n;
  endfunction : csr_write

  function automatic logic [31:0] csr_read(tpc_csr_s c);
    logic [31:0] r;
    r = '0;
    r[PINSEL_LSB +: 2] = c.pinsel;
    r[MODE_LSB +: 3]   = c.mode;
    r[GPO_BIT]         = c.gpo_level;
    return r;
  endfunction : csr_read

  always_comb
  begin
    state_next = state_reg;
    req  = wb_req.cyc && wb_req.stb && !state_reg.ack && !state_reg.err;
    hit0 = (wb_req.adr == TIMER0_CSR_OFF);
    hit1 = (wb_req.adr == TIMER1_CSR_OFF);
    hitl = (wb_req.adr == PIN_LEVEL_OFF);
    state_next.ack = 1'b0;
    state_next.err = 1'b0;
    if (req)
    begin
      state_next.ack   = hit0 || hit1 || hitl;
      state_next.err   = !(hit0 || hit1 || hitl);
      state_next.rdata = '0;
      if (wb_req.we)
      begin
        if (hit0)
        begin
          state_next.timer0_ctrl_status_reg =
            csr_write(state_reg.timer0_ctrl_status_reg, wb_req.sel, wb_req.dat);
        end
        if (hit1)
        begin
          state_next.timer1_ctrl_status_reg =
            csr_write(state_reg.timer1_ctrl_status_reg, wb_req.sel, wb_req.dat);
        end
      end
      else if (hit0)
      begin
        state_next.rdata = csr_read(state_reg.timer0_ctrl_status_reg);
      end
      else if (hit1)
      begin
        state_next.rdata = csr_read(state_reg.timer1_ctrl_status_reg);
      end
      else if (hitl)
      begin
        state_next.rdata = {30'h0, level};
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg.timer0_ctrl_status_reg <= CSR_RESET;
      state_reg.timer1_ctrl_status_reg <= CSR_RESET;
      state_reg.ack                    <= 1'b0;
      state_reg.err                    <= 1'b0;
      state_reg.rdata                  <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign wb_rsp.ack = state_reg.ack;
  assign wb_rsp.err = state_reg.err;
  assign wb_rsp.dat = state_reg.rdata;

endmodule : tpc_pin_ctrl

// ### verilog/tpc_pkg.sv
// Purpose: Shared constants and types for the timer pin control block
// Assumes: Wishbone classic slave, 32-bit data, word-aligned registers
package tpc_pkg;

  localparam int unsigned NUM_TIMERS = 2;

  // Register byte offsets
  localparam logic [3:0] TIMER0_CSR_OFF = 4'h0;
  localparam logic [3:0] TIMER1_CSR_OFF = 4'h4;
  localparam logic [3:0] PIN_LEVEL_OFF  = 4'h8;

  // Control register field positions
  localparam int unsigned PINSEL_LSB = 0;
  localparam int unsigned MODE_LSB   = 4;
  localparam int unsigned GPO_BIT    = 8;

  // Pin usage selection
  typedef enum logic [1:0] {
    TPC_PIN_GPIO_IN  = 2'h0,
    TPC_PIN_GPIO_OUT = 2'h1,
    TPC_PIN_TIMER    = 2'h2
  } tpc_pinsel_e;

  // Timer operating modes
  typedef enum logic [2:0] {
    TPC_MODE_TIMER    = 3'h0,
    TPC_MODE_WATCHDOG = 3'h1,
    TPC_MODE_PWM      = 3'h2,
    TPC_MODE_EVENT    = 3'h3,
    TPC_MODE_MEASURE  = 3'h4
  } tpc_mode_e;

  // One timer control register
  typedef struct packed {
    logic        gpo_level;
    tpc_mode_e   mode;
    tpc_pinsel_e pinsel;
  } tpc_csr_s;

  localparam tpc_csr_s CSR_RESET = '{gpo_level: 1'b0, mode: TPC_MODE_TIMER,
                                     pinsel: TPC_PIN_GPIO_IN};

  // Output and output-enable of one two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } tpc_pin_out_s;

  // Wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } tpc_wb_req_s;

  // Wishbone answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } tpc_wb_rsp_s;

endpackage : tpc_pkg

// ### verilog/tpc_pin_cell.sv
// Purpose: Direction and function steering for one timer pin
// Assumes: Pin input already arrives from outside the clock domain
// Notes:   Three-flop synchroniser, change taken when stages two and three agree
`timescale 1ns/100ps
module tpc_pin_cell
  import tpc_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Configuration
  input  wire tpc_pkg::tpc_csr_s     csr,
  input  wire logic                  timer_out,
  // Pin
  input  wire logic                  pin_i,
  output tpc_pkg::tpc_pin_out_s      pin,
  // Sampled level and timer input
  output logic                       level,
  output logic                       timer_in
);

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
  } tpc_cell_state_s;

  tpc_cell_state_s state_reg;
  tpc_cell_state_s state_next;
  logic            timer_owns;
  logic            mode_is_input;

  always_comb
  begin
    state_next = state_reg;
    state_next.sync = {state_reg.sync[1:0], pin_i};
    if (state_reg.sync[1] == state_reg.sync[2])
    begin
      state_next.level = state_reg.sync[2];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_comb
  begin
    timer_owns    = (csr.pinsel == TPC_PIN_TIMER);
    mode_is_input = (csr.mode == TPC_MODE_EVENT) || (csr.mode == TPC_MODE_MEASURE);
    timer_in      = timer_owns && mode_is_input && state_reg.level;
    pin.oe        = 1'b0;
    pin.o         = 1'b0;
    if (csr.pinsel == TPC_PIN_GPIO_OUT)
    begin
      pin.oe = 1'b1;
      pin.o  = csr.gpo_level;
    end
    else if (timer_owns && !mode_is_input)
    begin
      pin.oe = 1'b1;
      pin.o  = timer_out;
    end
  end

  assign level = state_reg.level;

endmodule : tpc_pin_cell

// ### verif/tpc_asserts.sv
// Purpose: Port checks for tpc_pin_ctrl
// Assumes: Bound from the bench
// Notes:   One clock domain
`timescale 1ns/100ps
module tpc_asserts
  import tpc_pkg::*;
(
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // Bus
  input wire tpc_pkg::tpc_wb_req_s wb_req,
  input wire tpc_pkg::tpc_wb_rsp_s wb_rsp,
  // Timer and pins
  input wire logic [1:0]           timer_in,
  input wire tpc_pkg::tpc_mode_e [1:0] timer_mode,
  input wire logic [1:0]           timer_pin_o,
  input wire logic [1:0]           timer_pin_oe
);
  logic [1:0] evt;
  assign evt[0] = timer_mode[0] inside {TPC_MODE_EVENT, TPC_MODE_MEASURE};
  assign evt[1] = timer_mode[1] inside {TPC_MODE_EVENT, TPC_MODE_MEASURE};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack && !wb_rsp.err;
  endsequence
  chk_ack_after_req: assert property (s_req |=> wb_rsp.ack || wb_rsp.err)
    else $error("no answer one cycle after request");
  chk_ack_one_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  chk_ack_has_cause: assert property (wb_rsp.ack |-> $past(wb_req.stb) && !wb_rsp.err)
    else $error("ack without request");
  chk_reset_idle: assert property ($fell(rst) |-> timer_pin_oe == 2'h0 &&
    timer_in == 2'h0 && timer_mode == '0)
    else $error("pins not idle after reset");
  chk_oe_by_write: assert property ($changed(timer_pin_oe) |-> wb_rsp.ack)
    else $error("drive changed without write");
  chk_mode_by_write: assert property ($changed(timer_mode) |-> wb_rsp.ack)
    else $error("mode changed without write");
  chk_input_no_drive: assert property ((timer_in & timer_pin_oe) == 2'h0)
    else $error("timer input pin driven");
  chk_input_mode: assert property ((timer_in & ~evt) == 2'h0)
    else $error("timer input in output mode");
  chk_quiet_out: assert property ((timer_pin_o & ~timer_pin_oe) == 2'h0)
    else $error("output value while released");
endmodule : tpc_asserts

// ### verif/tpc_pin_model.sv
// Purpose: Board side of both timer pins
// Assumes: Pull-up when nothing drives
// Notes:   Device driver wins over source
`timescale 1ns/100ps
module tpc_pin_model
(
  // Device side
  input  wire logic [1:0] pin_o,
  input  wire logic [1:0] pin_oe,
  // Board source
  input  wire logic [1:0] src_en,
  input  wire logic [1:0] src_val,
  // Level seen by device
  output logic      [1:0] pin_i
);
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & (src_val | ~src_en));
endmodule : tpc_pin_model

// ### verif/tpc_pin_ctrl_tb.sv
// Purpose: Bench for tpc_pin_ctrl
// Assumes: Ack one cycle after request
// Notes:   Pins through tpc_pin_model
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tpc_pin_ctrl_tb;
  import tpc_pkg::*;
  logic            core_clk = 1'b0;
  logic            rst = 1'b1;
  tpc_wb_req_s     wb_req = '0;
  tpc_wb_rsp_s     wb_rsp;
  logic [1:0]      timer_out = 2'h0, src_en = 2'h0, src_val = 2'h0;
  logic [1:0]      timer_in, pin_i, pin_o, pin_oe;
  tpc_mode_e [1:0] timer_mode;
  logic [31:0]     rd;
  logic            e;
  int              miscompares = 0, n_checks = 0, cycles = 0, i, m;
  initial forever #2 core_clk = ~core_clk;
  tpc_pin_ctrl dut (.core_clk(core_clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .timer_out(timer_out), .timer_in(timer_in), .timer_mode(timer_mode),
    .timer_pin_i(pin_i), .timer_pin_o(pin_o), .timer_pin_oe(pin_oe));
  tpc_pin_model u_pins (.pin_o(pin_o), .pin_oe(pin_oe), .src_en(src_en),
    .src_val(src_val), .pin_i(pin_i));
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
    input logic [3:0] sel);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: d};
    do @(posedge core_clk); while (wb_rsp.ack !== 1'b1 && wb_rsp.err !== 1'b1);
    rd = wb_rsp.dat;
    e = wb_rsp.err;
    wb_req <= '0;
    #1;
  endtask : wb
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    src_en <= 2'h3;
    src_val <= 2'h3;
    #1;
    `CHK(pin_oe, 2'h0)
    for (i = 0; i < 2; i++)
    begin
      wb(1'b0, 4'(i * 4), 32'h0, 4'hf);
      `CHK(rd, 32'h0)
    end
    wb(1'b0, 4'h8, 32'h0, 4'hf);
    `CHK(rd, 32'h3)
    `CHK(timer_in, 2'h0)
    $display("reset test done");
    for (i = 0; i < 2; i++)
      for (m = 0; m < 5; m++)
      begin
        @(posedge core_clk);
        timer_out <= {2{m[0]}};
        wb(1'b1, 4'(i * 4), 32'(m << 4) | 32'h2, 4'h1);
        repeat (5) @(posedge core_clk);
        #1;
        `CHK(pin_oe[i], 1'(m < 3))
        `CHK(pin_o[i], 1'(m < 3 && m[0]))
        `CHK(timer_in[i], 1'(m >= 3))
        `CHK(timer_mode[i], tpc_mode_e'(m))
        `CHK(pin_oe[1 - i], 1'b0)
      end
    $display("mode test done");
    @(posedge core_clk);
    src_val <= 2'h0;
    wb(1'b1, 4'h0, 32'h101, 4'h3);
    `CHK(pin_oe[0], 1'b1)
    `CHK(pin_o[0], 1'b1)
    repeat (5) @(posedge core_clk);
    wb(1'b0, 4'h8, 32'h0, 4'hf);
    `CHK(rd, 32'h1)
    `CHK(timer_in[1], 1'b0)
    wb(1'b1, 4'h0, 32'h73, 4'h3);
    `CHK(pin_oe[0], 1'b1)
    `CHK(pin_o[0], 1'b0)
    wb(1'b0, 4'h0, 32'h0, 4'hf);
    `CHK(rd, 32'h1)
    wb(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(e, 1'b1)
    $display("gpio test done");
    tally_and_finish();
  end
endmodule : tpc_pin_ctrl_tb
bind tpc_pin_ctrl tpc_asserts u_chk (.core_clk(core_clk), .rst(rst), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .timer_in(timer_in), .timer_mode(timer_mode),
  .timer_pin_o(timer_pin_o), .timer_pin_oe(timer_pin_oe));
